// >>> verilog/card_end.sv
// Functional notes
// - Host pulses read strobe for I/O reads
// - Card drives read data only during strobe; card here starts and stops driving three clocks after each strobe edge
// - True IDE without Ultra DMA: same gating
// - Host asserts DMA-ready to accept data-in
// - DMA-ready negated pauses card data-in words
// - Host strobe accompanies each data-out word
// - Card latches word on both strobe edges
// - Missing strobe edges pause, no error
// - Host needs both card-detects low first
// - Request held until acknowledge, then renegotiated; card drops it unacknowledged if Ultra DMA ends first
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  // Space kept as its own flop so the ready port is registered
  logic             space_reg;
  logic             empty_reg;
  wire              push = in_valid && space_reg;
  wire              pop  = out_ready && !empty_reg;

  assign in_ready   = space_reg;
  assign out_valid  = !empty_reg;
  assign out_data   = mem[rd_ptr_reg];
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      space_reg  <= 1'b1;
      empty_reg  <= 1'b1;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      space_reg <= (count_next != (AW+1)'(DEPTH));
      empty_reg <= (count_next == '0);
    end
  end
endmodule : word_fifo

module card_end (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  card_link_if.card                              link,
  input  wire logic                              io_mode,
  input  wire logic                              true_ide,
  input  wire logic                              udma_rd_active,
  input  wire logic                              udma_wr_active,
  input  wire logic [card_port_pkg::DATA_W-1:0]  pio_rd_data,
  input  wire logic [card_port_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                              rd_valid,
  output logic                                   rd_ready,
  output logic [card_port_pkg::DATA_W-1:0]       wr_data,
  output logic                                   wr_valid
);
  localparam int W = card_port_pkg::DATA_W;

  // Two-flop synchronisers for everything the host drives
  logic [1:0]   ior_sync_reg;
  logic [1:0]   rdy_sync_reg;
  logic [1:0]   ack_sync_reg;
  logic [1:0]   hstb_sync_reg;
  logic         hstb_last_reg;
  logic [W-1:0] bus_meta_reg;
  logic [W-1:0] bus_sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ior_sync_reg  <= 2'h3;
      rdy_sync_reg  <= 2'h3;
      ack_sync_reg  <= 2'h3;
      hstb_sync_reg <= 2'h0;
      hstb_last_reg <= 1'b0;
      bus_meta_reg  <= card_port_pkg::DATA_RESET;
      bus_sync_reg  <= card_port_pkg::DATA_RESET;
    end else begin
      ior_sync_reg  <= {ior_sync_reg[0], link.ior_n};
      rdy_sync_reg  <= {rdy_sync_reg[0], link.hdmardy_n};
      ack_sync_reg  <= {ack_sync_reg[0], link.dmack_n};
      hstb_sync_reg <= {hstb_sync_reg[0], link.hstrobe};
      hstb_last_reg <= hstb_sync_reg[1];
      bus_meta_reg  <= link.d_bus;
      bus_sync_reg  <= bus_meta_reg;
    end
  end

  wire ior_low   = !ior_sync_reg[1];
  wire host_rdy  = !rdy_sync_reg[1];
  wire acked     = !ack_sync_reg[1];
  wire udma_on   = udma_rd_active || udma_wr_active;
  // I/O interface in either PC Card I/O or True IDE outside Ultra DMA
  wire pio_gate  = ior_low && (io_mode || (true_ide && !udma_on));
  wire hstb_edge = hstb_sync_reg[1] ^ hstb_last_reg;

  // Data-in path: buffered words paced onto the bus
  logic [W-1:0] fifo_data;
  logic         fifo_valid;
  logic         fifo_pop;

  word_fifo #(
    .WIDTH (W),
    .DEPTH (card_port_pkg::FIFO_DEPTH)
  ) word_fifo_i (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (rd_data),
    .in_valid  (rd_valid),
    .in_ready  (rd_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  typedef enum logic [1:0] {IDLE, BURST} burst_t;
  burst_t                             state_reg;
  burst_t                             state_next;
  logic [card_port_pkg::PHASE_W-1:0]  phase_reg;
  logic                               dmarq_reg;
  logic                               dmarq_next;
  logic                               strobe_reg;
  logic [W-1:0]                       d_out_reg;
  logic [W-1:0]                       d_out_next;
  logic                               d_oe_reg;
  logic                               d_oe_next;
  logic                               cd_reg;
  logic [W-1:0]                       wr_data_reg;
  logic                               wr_valid_reg;

  wire in_burst   = (state_reg == BURST);
  wire word_slot  = (phase_reg == card_port_pkg::PHASE_RESET);
  wire edge_slot  = (phase_reg == card_port_pkg::PHASE_EDGE);
  // A word only leaves while the host is ready; otherwise the burst waits
  assign fifo_pop = in_burst && word_slot && host_rdy && fifo_valid;
  // Strobe toggles for a word put out at the start of this slot
  logic word_out_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE:    if (udma_rd_active && acked) state_next = BURST;
      BURST:   if (!udma_rd_active || !acked) state_next = IDLE;
      default: state_next = IDLE;
    endcase
  end

  // Request stays up until acknowledged; drops once drained on reads, or whenever Ultra DMA ends
  always_comb begin
    dmarq_next = dmarq_reg;
    if (!dmarq_reg && !acked && udma_on && (udma_wr_active || fifo_valid)) begin
      dmarq_next = 1'b1;
    end else if (dmarq_reg && acked && udma_rd_active && !fifo_valid) begin
      dmarq_next = 1'b0;
    end else if (dmarq_reg && !udma_on) begin
      dmarq_next = 1'b0;
    end
  end

  always_comb begin
    d_out_next = d_out_reg;
    d_oe_next  = 1'b0;
    if (pio_gate) begin
      d_out_next = pio_rd_data;
      d_oe_next  = 1'b1;
    end else if (in_burst) begin
      d_oe_next = 1'b1;
      if (fifo_pop) d_out_next = fifo_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= IDLE;
      phase_reg    <= card_port_pkg::PHASE_RESET;
      dmarq_reg    <= 1'b0;
      strobe_reg   <= 1'b0;
      word_out_reg <= 1'b0;
      d_out_reg    <= card_port_pkg::DATA_RESET;
      d_oe_reg     <= 1'b0;
      cd_reg       <= 1'b1;
    end else begin
      state_reg <= state_next;
      dmarq_reg <= dmarq_next;
      d_out_reg <= d_out_next;
      d_oe_reg  <= d_oe_next;
      cd_reg    <= 1'b0;
      if (!in_burst || phase_reg == card_port_pkg::PHASE_LAST) begin
        phase_reg <= card_port_pkg::PHASE_RESET;
      end else begin
        phase_reg <= phase_reg + 1'b1;
      end
      if (fifo_pop) word_out_reg <= 1'b1;
      else if (edge_slot) word_out_reg <= 1'b0;
      // Data settles on the bus before the strobe edge
      if (edge_slot && word_out_reg) strobe_reg <= !strobe_reg;
    end
  end

  // Data-out: every host strobe edge is a word; no edge, no word
  wire wr_take = udma_wr_active && acked && hstb_edge;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_data_reg  <= card_port_pkg::DATA_RESET;
      wr_valid_reg <= 1'b0;
    end else begin
      wr_valid_reg <= wr_take;
      if (wr_take) wr_data_reg <= bus_sync_reg;
    end
  end

  assign wr_data          = wr_data_reg;
  assign wr_valid         = wr_valid_reg;
  assign link.dmarq       = dmarq_reg;
  assign link.card_strobe = strobe_reg;
  assign link.card_d_out  = d_out_reg;
  assign link.card_d_oe   = d_oe_reg;
  // Card-detects tied low in every mode once out of reset
  assign link.cd1_n       = cd_reg;
  assign link.cd2_n       = cd_reg;
endmodule : card_end
`default_nettype wire

// >>> shared/card_port_pkg.sv
package card_port_pkg;
  localparam int DATA_W          = 16;
  localparam int FIFO_DEPTH      = 8;
  localparam int CLK_PERIOD_NS   = 10;
  // Host data-out strobe period, one word per half period
  localparam int STROBE_PERIOD_NS = 80;
  localparam int STROBE_HALF_CYC  = STROBE_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int DATA_SETUP_CYC   = STROBE_HALF_CYC / 2;
  localparam int PHASE_W          = 2;
  localparam logic [PHASE_W-1:0] PHASE_LAST  = PHASE_W'(STROBE_HALF_CYC - 1);
  localparam logic [PHASE_W-1:0] PHASE_EDGE  = PHASE_W'(DATA_SETUP_CYC);
  localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;
  // Host read strobe low time
  localparam int PIO_STROBE_NS   = 165;
  localparam int PIO_STROBE_CYC  = (PIO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIO_CNT_W       = 5;
  localparam logic [PIO_CNT_W-1:0] PIO_CNT_LAST = PIO_CNT_W'(PIO_STROBE_CYC - 1);
  localparam logic [DATA_W-1:0]  DATA_RESET = 16'h0000;
endpackage : card_port_pkg

// >>> shared/card_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface card_link_if;
  logic                              ior_n;
  logic                              hdmardy_n;
  logic                              hstrobe;
  logic                              dmack_n;
  logic                              dmarq;
  logic                              card_strobe;
  logic                              cd1_n;
  logic                              cd2_n;
  logic [card_port_pkg::DATA_W-1:0]  card_d_out;
  logic                              card_d_oe;
  logic [card_port_pkg::DATA_W-1:0]  host_d_out;
  logic                              host_d_oe;
  logic [card_port_pkg::DATA_W-1:0]  d_bus;

  // Bus level from the enables; released bus reads as zero
  assign d_bus = card_d_oe ? card_d_out : (host_d_oe ? host_d_out : card_port_pkg::DATA_RESET);

  modport card (
    input  ior_n, hdmardy_n, hstrobe, dmack_n, d_bus,
    output dmarq, card_strobe, cd1_n, cd2_n, card_d_out, card_d_oe
  );
  modport host (
    output ior_n, hdmardy_n, hstrobe, dmack_n, host_d_out, host_d_oe,
    input  dmarq, card_strobe, cd1_n, cd2_n, d_bus
  );
endinterface : card_link_if
`default_nettype wire

// >>> verilog/host_end.sv
`timescale 1ns/1ns
`default_nettype none
module host_end (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  card_link_if.host                              link,
  input  wire logic                              pio_req,
  output logic [card_port_pkg::DATA_W-1:0]       pio_data,
  output logic                                   pio_done,
  input  wire logic                              udma_rd_en,
  input  wire logic                              udma_wr_en,
  input  wire logic                              rx_ready,
  output logic [card_port_pkg::DATA_W-1:0]       rx_data,
  output logic                                   rx_valid,
  input  wire logic [card_port_pkg::DATA_W-1:0]  tx_data,
  input  wire logic                              tx_valid,
  output logic                                   tx_ready,
  output logic                                   card_present
);
  localparam int W = card_port_pkg::DATA_W;

  logic [1:0]   rq_sync_reg;
  logic [1:0]   cstb_sync_reg;
  logic         cstb_last_reg;
  logic [1:0]   cd1_sync_reg;
  logic [1:0]   cd2_sync_reg;
  logic [W-1:0] bus_meta_reg;
  logic [W-1:0] bus_sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rq_sync_reg   <= 2'h0;
      cstb_sync_reg <= 2'h0;
      cstb_last_reg <= 1'b0;
      cd1_sync_reg  <= 2'h3;
      cd2_sync_reg  <= 2'h3;
      bus_meta_reg  <= card_port_pkg::DATA_RESET;
      bus_sync_reg  <= card_port_pkg::DATA_RESET;
    end else begin
      rq_sync_reg   <= {rq_sync_reg[0], link.dmarq};
      cstb_sync_reg <= {cstb_sync_reg[0], link.card_strobe};
      cstb_last_reg <= cstb_sync_reg[1];
      cd1_sync_reg  <= {cd1_sync_reg[0], link.cd1_n};
      cd2_sync_reg  <= {cd2_sync_reg[0], link.cd2_n};
      bus_meta_reg  <= link.d_bus;
      bus_sync_reg  <= bus_meta_reg;
    end
  end

  wire present  = !cd1_sync_reg[1] && !cd2_sync_reg[1];
  wire udma_en  = udma_rd_en || udma_wr_en;
  wire cstb_edg = cstb_sync_reg[1] ^ cstb_last_reg;

  logic                               ior_n_reg;
  logic [card_port_pkg::PIO_CNT_W-1:0] pio_cnt_reg;
  logic [W-1:0]                       pio_data_reg;
  logic                               pio_done_reg;
  logic                               ack_reg;
  logic                               rdy_n_reg;
  logic [W-1:0]                       rx_data_reg;
  logic                               rx_valid_reg;
  logic                               present_reg;
  logic [card_port_pkg::PHASE_W-1:0]  phase_reg;
  logic                               hstb_reg;
  logic                               word_reg;
  logic [W-1:0]                       d_out_reg;
  logic                               d_oe_reg;

  wire pio_start = pio_req && ior_n_reg && present && !udma_en;
  wire pio_end   = !ior_n_reg && (pio_cnt_reg == card_port_pkg::PIO_CNT_LAST);
  wire wr_burst  = udma_wr_en && ack_reg;
  wire word_slot = (phase_reg == card_port_pkg::PHASE_RESET);
  wire tx_take   = wr_burst && word_slot && tx_valid;
  // Ack may drop before the last word's strobe edge has crossed over
  wire rx_take   = udma_rd_en && cstb_edg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ior_n_reg    <= 1'b1;
      pio_cnt_reg  <= '0;
      pio_data_reg <= card_port_pkg::DATA_RESET;
      pio_done_reg <= 1'b0;
      ack_reg      <= 1'b0;
      rdy_n_reg    <= 1'b1;
      rx_data_reg  <= card_port_pkg::DATA_RESET;
      rx_valid_reg <= 1'b0;
      present_reg  <= 1'b0;
    end else begin
      present_reg  <= present;
      pio_done_reg <= pio_end;
      if (pio_start) ior_n_reg <= 1'b0;
      else if (pio_end) ior_n_reg <= 1'b1;
      pio_cnt_reg <= ior_n_reg ? '0 : pio_cnt_reg + 1'b1;
      if (pio_end) pio_data_reg <= bus_sync_reg;
      ack_reg <= present && udma_en && rq_sync_reg[1];
      // Ready dropped while the user cannot take more
      rdy_n_reg    <= !(udma_rd_en && ack_reg && rx_ready);
      rx_valid_reg <= rx_take;
      if (rx_take) rx_data_reg <= bus_sync_reg;
    end
  end

  // Own strobe divider; no word offered means no edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= card_port_pkg::PHASE_RESET;
      hstb_reg  <= 1'b0;
      word_reg  <= 1'b0;
      d_out_reg <= card_port_pkg::DATA_RESET;
      d_oe_reg  <= 1'b0;
    end else begin
      d_oe_reg <= wr_burst;
      if (!wr_burst || phase_reg == card_port_pkg::PHASE_LAST) begin
        phase_reg <= card_port_pkg::PHASE_RESET;
      end else begin
        phase_reg <= phase_reg + 1'b1;
      end
      if (tx_take) begin
        d_out_reg <= tx_data;
        word_reg  <= 1'b1;
      end else if (phase_reg == card_port_pkg::PHASE_EDGE) begin
        word_reg <= 1'b0;
      end
      if (phase_reg == card_port_pkg::PHASE_EDGE && word_reg) hstb_reg <= !hstb_reg;
    end
  end

  assign tx_ready        = tx_take;
  assign pio_data        = pio_data_reg;
  assign pio_done        = pio_done_reg;
  assign rx_data         = rx_data_reg;
  assign rx_valid        = rx_valid_reg;
  assign card_present    = present_reg;
  assign link.ior_n      = ior_n_reg;
  assign link.hdmardy_n  = rdy_n_reg;
  assign link.dmack_n    = !ack_reg;
  assign link.hstrobe    = hstb_reg;
  assign link.host_d_out = d_out_reg;
  assign link.host_d_oe  = d_oe_reg;
endmodule : host_end
`default_nettype wire

// >>> verif/card_link_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module link_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ior_n,
  input wire logic hdmardy_n,
  input wire logic hstrobe,
  input wire logic dmack_n,
  input wire logic dmarq,
  input wire logic card_strobe,
  input wire logic cd1_n,
  input wire logic cd2_n,
  input wire logic card_d_oe,
  input wire logic host_d_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Strobe stays low 17 cycles, then lifts
  sequence ior_hold_s;
    ##16 !ior_n ##1 ior_n;
  endsequence
  // Card lets go late: it sees strobe and ack only through synchronisers
  sequence drive_recent_s;
    !ior_n || !$past(ior_n) || !$past(ior_n, 2) || !$past(ior_n, 3) || !$past(ior_n, 4) ||
      !dmack_n || !$past(dmack_n) || !$past(dmack_n, 2) || !$past(dmack_n, 3) ||
      !$past(dmack_n, 4);
  endsequence
  ior_width_a: assert property ($fell(ior_n) |-> ior_hold_s)
    else $error("read strobe width wrong");
  bus_gate_a: assert property (card_d_oe |-> drive_recent_s)
    else $error("card drove bus without read strobe");
  detect_first_a: assert property ($fell(ior_n) |-> !cd1_n && !cd2_n)
    else $error("read strobe before card detect");
  detect_low_a: assert property ($past(rst_n) |-> !cd1_n && !cd2_n)
    else $error("card detect not low");
  req_hold_a: assert property (dmarq && dmack_n |=> dmarq)
    else $error("request dropped before acknowledge");
  req_drop_a: assert property ($fell(dmarq) |-> !dmack_n)
    else $error("request fell without acknowledge");
  strobe_ack_a: assert property ($changed(card_strobe) |-> !dmack_n)
    else $error("data-in strobe without acknowledge");
  pause_in_a: assert property (hdmardy_n [*8] |-> $stable(card_strobe))
    else $error("data-in word during host pause");
  hstrobe_data_a: assert property ($changed(hstrobe) |-> host_d_oe)
    else $error("host strobe edge without data");
endmodule : link_checker
`default_nettype wire

// >>> verif/card_host_read_strobe_udma_pacing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module card_host_read_strobe_udma_pacing_tb;
  typedef logic [card_port_pkg::DATA_W-1:0] word_t;
  logic  clk, rst_n, io_mode, true_ide, udma_rd_active, udma_wr_active;
  logic  rd_valid, rd_ready, wr_valid, pio_req, pio_done, udma_rd_en, udma_wr_en;
  logic  rx_ready, rx_valid, tx_valid, tx_ready, card_present;
  word_t pio_rd_data, rd_data, wr_data, pio_data, rx_data, tx_data;
  word_t rxq[$];
  word_t wrq[$];
  int    errors = 0;
  int    compares = 0;
  int    n;

  card_link_if card_link_if_i ();
  card_end card_end_i (.clk(clk), .rst_n(rst_n), .link(card_link_if_i), .io_mode(io_mode),
    .true_ide(true_ide), .udma_rd_active(udma_rd_active), .udma_wr_active(udma_wr_active),
    .pio_rd_data(pio_rd_data), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .wr_data(wr_data), .wr_valid(wr_valid));
  host_end host_end_i (.clk(clk), .rst_n(rst_n), .link(card_link_if_i), .pio_req(pio_req),
    .pio_data(pio_data), .pio_done(pio_done), .udma_rd_en(udma_rd_en), .udma_wr_en(udma_wr_en),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .card_present(card_present));
  link_checker link_checker_i (.clk(clk), .rst_n(rst_n), .ior_n(card_link_if_i.ior_n),
    .hdmardy_n(card_link_if_i.hdmardy_n), .hstrobe(card_link_if_i.hstrobe),
    .dmack_n(card_link_if_i.dmack_n), .dmarq(card_link_if_i.dmarq),
    .card_strobe(card_link_if_i.card_strobe), .cd1_n(card_link_if_i.cd1_n),
    .cd2_n(card_link_if_i.cd2_n), .card_d_oe(card_link_if_i.card_d_oe),
    .host_d_oe(card_link_if_i.host_d_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Flops are read here before their edge updates land
  always @(posedge clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (wr_valid === 1'b1) wrq.push_back(wr_data);
  end

  task automatic check(input word_t seen, input word_t exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int cnt);
    repeat (cnt) @(posedge clk);
    #1;
  endtask : tick

  task automatic end_of_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic detect_scen;
    tick(8);
    check(16'(card_link_if_i.cd1_n), 16'h0000);
    check(16'(card_link_if_i.cd2_n), 16'h0000);
    check(16'(card_present), 16'h0001);
  endtask : detect_scen

  task automatic pio_read(input logic io, input logic ide, input logic rda, input word_t val,
                          input word_t exp);
    io_mode = io;
    true_ide = ide;
    udma_rd_active = rda;
    pio_rd_data = val;
    pio_req = 1'b1;
    tick(1);
    pio_req = 1'b0;
    for (int i = 0; i < 40 && pio_done !== 1'b1; i++) tick(1);
    check(16'(pio_done), 16'h0001);
    check(pio_data, exp);
    tick(2);
  endtask : pio_read

  task automatic pio_scen;
    pio_read(1'b1, 1'b0, 1'b0, 16'hA5C3, 16'hA5C3);
    pio_read(1'b0, 1'b1, 1'b0, 16'h5A3C, 16'h5A3C);
    pio_read(1'b0, 1'b1, 1'b1, 16'h1234, 16'h0000);
    pio_read(1'b0, 1'b0, 1'b0, 16'hFFFF, 16'h0000);
  endtask : pio_scen

  task automatic udma_read_scen;
    udma_rd_active = 1'b1;
    // Ninth word must be refused by the full buffer
    for (int i = 0; i < 9; i++) begin
      rd_data = 16'hC000 + 16'(i);
      rd_valid = 1'b1;
      for (int j = 0; j < 20; j++) begin
        @(posedge clk);
        if (rd_ready === 1'b1) break;
      end
      #1;
    end
    check(16'(rd_ready), 16'h0000);
    rd_valid = 1'b0;
    check(16'(card_link_if_i.dmarq), 16'h0001);
    udma_rd_en = 1'b1;
    rx_ready = 1'b1;
    for (int i = 0; i < 300 && rxq.size() < 3; i++) tick(1);
    rx_ready = 1'b0;
    tick(10);
    n = rxq.size();
    tick(24);
    check(16'(rxq.size()), 16'(n));
    rx_ready = 1'b1;
    for (int i = 0; i < 300 && rxq.size() < 8; i++) tick(1);
    check(16'(rxq.size()), 16'h0008);
    for (int i = 0; i < 8; i++) check(rxq[i], 16'hC000 + 16'(i));
    tick(10);
    check(16'(card_link_if_i.dmarq), 16'h0000);
    udma_rd_active = 1'b0;
    tick(1);
    udma_rd_en = 1'b0;
    tick(10);
  endtask : udma_read_scen

  task automatic udma_write_scen;
    udma_wr_active = 1'b1;
    udma_wr_en = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        tx_valid = 1'b0;
        tick(20);
        check(16'(wrq.size()), 16'h0003);
      end
      tx_data = 16'h3C00 + 16'(i);
      tx_valid = 1'b1;
      for (int j = 0; j < 60; j++) begin
        @(posedge clk);
        if (tx_ready === 1'b1) break;
      end
      #1;
    end
    tx_valid = 1'b0;
    for (int i = 0; i < 100 && wrq.size() < 6; i++) tick(1);
    check(16'(wrq.size()), 16'h0006);
    for (int i = 0; i < 6; i++) check(wrq[i], 16'h3C00 + 16'(i));
    udma_wr_active = 1'b0;
    tick(1);
    udma_wr_en = 1'b0;
    tick(10);
  endtask : udma_write_scen

  initial begin
    {rst_n, io_mode, true_ide, udma_rd_active, udma_wr_active, rd_valid} = 6'h00;
    {pio_req, udma_rd_en, udma_wr_en, rx_ready, tx_valid} = 5'h00;
    pio_rd_data = 16'h0000;
    rd_data = 16'h0000;
    tx_data = 16'h0000;
    tick(4);
    rst_n = 1'b1;
    detect_scen();
    pio_scen();
    udma_read_scen();
    udma_write_scen();
    end_of_test();
  end

  // Whole run needs well under 20 us
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule : card_host_read_strobe_udma_pacing_tb
`default_nettype wire
